// [src/ubp_pkg.sv]
// constants, types and register map of the serial port block
// assumes a single 100 MHz clock and register access over APB
package ubp_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 12;
  localparam logic [9:0]  IDX_PORT0      = 10'h080;
  localparam logic [9:0]  IDX_POWER      = 10'h087;
  localparam logic [9:0]  IDX_CTRL       = 10'h098;
  localparam logic [9:0]  IDX_DATA       = 10'h099;
  localparam logic [9:0]  IDX_IRQ_EN     = 10'h0A8;
  localparam logic [9:0]  IDX_RELOAD_LO  = 10'h0AA;
  localparam logic [9:0]  IDX_RELOAD_HI  = 10'h0BA;
  localparam logic [9:0]  IDX_CTRL2      = 10'h0D8;
  localparam logic [9:0]  IDX_OPEN_DRAIN = 10'h0E4;
  localparam logic [9:0]  IDX_DIRECTION  = 10'h0F9;
  localparam logic [9:0]  IDX_STATUS     = 10'h100;
  localparam logic [9:0]  IDX_MASK       = 10'h101;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_BAUD_DOUBLE = 7;
  localparam int BIT_GLOBAL_IE   = 7;
  localparam int BIT_SERIAL_IE   = 4;
  localparam int BIT_RX_OD       = 4;
  localparam int BIT_TX_OD       = 3;
  localparam int BIT_RX_PIN      = 6;
  localparam int BIT_TX_PIN      = 5;
  localparam int BIT_MODE_LO     = 6;
  localparam int BIT_RX_EN       = 4;
  localparam int BIT_TB8         = 3;
  localparam int BIT_RB8         = 2;
  localparam int BIT_TX_DONE     = 1;
  localparam int BIT_RX_DONE     = 0;
  localparam int BIT_BAUD_SRC    = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_MASK = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 100_000_000;
  localparam int OVS          = 4;    // ticks per bit
  localparam int MODE0_DIV    = 12;
  localparam int MODE2_DIV    = 64;
  localparam int RELOAD_MUL   = 64;
  localparam int RELOAD_SPAN  = 1024;
  localparam int T1_DIV       = 32;
  localparam int PERIOD_W     = 16;
  localparam int MID_PHASE    = 1;    // tick index at bit centre

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE0, MODE1, MODE2, MODE3} ubp_mode_e;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ubp_tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ubp_rx_state_e;

  typedef struct packed {
    logic o;   // level driven when enabled
    logic oe;  // high while driving
  } ubp_pin_s;

endpackage

// [src/ubp_baud_gen.sv]
// tick divider for one serial direction
// assumes src_en is a one-cycle pulse in the pclk domain
`timescale 1ns/1ps
module ubp_baud_gen #(
  parameter int W = ubp_pkg::PERIOD_W
) (
  input  wire logic         pclk,     // clock
  input  wire logic         presetn,  // async reset, low
  input  wire logic         restart,  // realign count
  input  wire logic         src_en,   // source pulse
  input  wire logic [W-1:0] period,   // pulses per tick
  output logic              tick      // one-cycle tick
);

  if (W < 2) begin : g_chk
    $error("ubp_baud_gen: W too small");
  end

  logic [W-1:0] cnt_q;
  logic         last;

  assign last = (cnt_q >= period - W'(1));
  assign tick = src_en & last & ~restart;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (restart) begin
      cnt_q <= '0;
    end else if (src_en) begin
      cnt_q <= last ? '0 : cnt_q + W'(1);
    end
  end

endmodule

// [src/ubp_serial_port.sv]
// serial port: apb registers, baud timing, transmitter, receiver, pins
// assumes pin inputs are synchronous to pclk; t1_overflow is a pulse
`timescale 1ns/1ps
module ubp_serial_port (
  input  wire logic                        pclk,         // 100 MHz clock
  input  wire logic                        presetn,      // async reset, low
  input  wire logic                        psel,         // apb select
  input  wire logic                        penable,      // apb enable
  input  wire logic                        pwrite,       // apb direction
  input  wire logic [ubp_pkg::ADDR_W-1:0]  paddr,        // apb byte address
  input  wire logic [31:0]                 pwdata,       // apb write data
  output logic      [31:0]                 prdata,       // apb read data
  output logic                             pready,       // apb ready
  output logic                             pslverr,      // apb error
  input  wire logic                        t1_overflow,  // timer source pulse
  input  wire logic                        tx_pin_i,     // transmit pin level
  output ubp_pkg::ubp_pin_s                tx_pin,       // transmit pin drive
  input  wire logic                        rx_pin_i,     // receive pin level
  output ubp_pkg::ubp_pin_s                rx_pin,       // receive pin drive
  output logic                             irq           // serial interrupt
);

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  logic [9:0] idx;
  logic       setup;
  logic       wr;
  logic       mapped;

  assign idx    = paddr[ubp_pkg::ADDR_W-1:2];
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite & mapped;
  assign pready = 1'b1;

  always_comb begin
    case (idx)
      ubp_pkg::IDX_PORT0, ubp_pkg::IDX_POWER, ubp_pkg::IDX_CTRL,
      ubp_pkg::IDX_DATA, ubp_pkg::IDX_IRQ_EN, ubp_pkg::IDX_RELOAD_LO,
      ubp_pkg::IDX_RELOAD_HI, ubp_pkg::IDX_CTRL2, ubp_pkg::IDX_OPEN_DRAIN,
      ubp_pkg::IDX_DIRECTION, ubp_pkg::IDX_STATUS, ubp_pkg::IDX_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] port0_latch_q;
  logic [7:0] power_q;
  logic [7:0] ctrl_q;
  logic [7:0] irq_en_q;
  logic [7:0] reload_lo_q;
  logic [1:0] reload_hi_q;
  logic       baud_src_q;
  logic [7:0] open_drain_q;
  logic [7:0] direction_q;
  logic [1:0] mask_q;
  logic [7:0] wbyte;

  assign wbyte = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port0_latch_q <= ubp_pkg::RST_BYTE;
      power_q       <= ubp_pkg::RST_BYTE;
      ctrl_q        <= ubp_pkg::RST_BYTE;
      irq_en_q      <= ubp_pkg::RST_BYTE;
      reload_lo_q   <= ubp_pkg::RST_BYTE;
      reload_hi_q   <= ubp_pkg::RST_BYTE[1:0];
      baud_src_q    <= 1'b0;
      open_drain_q  <= ubp_pkg::RST_BYTE;
      direction_q   <= ubp_pkg::RST_BYTE;
      mask_q        <= ubp_pkg::RST_MASK;
    end else if (wr) begin
      case (idx)
        ubp_pkg::IDX_PORT0:      port0_latch_q <= wbyte;
        ubp_pkg::IDX_POWER:      power_q       <= wbyte;
        ubp_pkg::IDX_CTRL:       ctrl_q        <= wbyte;
        ubp_pkg::IDX_IRQ_EN:     irq_en_q      <= wbyte;
        ubp_pkg::IDX_RELOAD_LO:  reload_lo_q   <= wbyte;
        ubp_pkg::IDX_RELOAD_HI:  reload_hi_q   <= wbyte[1:0];
        ubp_pkg::IDX_CTRL2:      baud_src_q    <= wbyte[ubp_pkg::BIT_BAUD_SRC];
        ubp_pkg::IDX_OPEN_DRAIN: open_drain_q  <= wbyte;
        ubp_pkg::IDX_DIRECTION:  direction_q   <= wbyte;
        ubp_pkg::IDX_MASK:       mask_q        <= wbyte[1:0];
        default: ;
      endcase
    end
  end

  ubp_pkg::ubp_mode_e serial_mode_field;
  logic               baud_double;
  logic [9:0]         baud_reload_value;
  logic               rx_enable;

  assign serial_mode_field = ubp_pkg::ubp_mode_e'(ctrl_q[ubp_pkg::BIT_MODE_LO +: 2]);
  assign baud_double       = power_q[ubp_pkg::BIT_BAUD_DOUBLE];
  assign baud_reload_value = {reload_hi_q, reload_lo_q};

  assign rx_enable = ctrl_q[ubp_pkg::BIT_RX_EN] & ~open_drain_q[ubp_pkg::BIT_RX_OD];

  // ----------------------------------------------------------------
  // baud timing: cycles (or timer pulses) per quarter bit
  // ----------------------------------------------------------------
  logic [ubp_pkg::PERIOD_W-1:0] period;
  logic [10:0]                  span;
  logic                         src_en;

  assign span = 11'(ubp_pkg::RELOAD_SPAN) - {1'b0, baud_reload_value};

  always_comb begin
    src_en = 1'b1;
    case (serial_mode_field)
      ubp_pkg::MODE0: period = 16'(ubp_pkg::MODE0_DIV / ubp_pkg::OVS);
      ubp_pkg::MODE2: period = 16'(ubp_pkg::MODE2_DIV / ubp_pkg::OVS) >> baud_double;
      default: begin
        if (baud_src_q) begin
          // 64 * (1024 - reload) cycles per bit, halved when doubled
          period = (16'(ubp_pkg::RELOAD_MUL / ubp_pkg::OVS) * {5'h00, span}) >> baud_double;
        end else begin
          src_en = t1_overflow;
          period = 16'(ubp_pkg::T1_DIV / ubp_pkg::OVS) >> baud_double;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  ubp_pkg::ubp_tx_state_e tx_state_q;
  logic [8:0]             tx_shift_q;
  logic [3:0]             tx_count_q;
  logic [1:0]             tx_phase_q;
  logic                   tx_tick;
  logic                   tx_load;
  logic                   tx_bit_end;
  logic                   tx_done_set;
  logic [3:0]             frame_bits;

  assign tx_load    = wr & (idx == ubp_pkg::IDX_DATA);
  assign tx_bit_end = tx_tick & (tx_phase_q == 2'(ubp_pkg::OVS - 1));
  assign frame_bits = serial_mode_field[1] ? 4'h9 : 4'h8;

  ubp_baud_gen #(
    .W(ubp_pkg::PERIOD_W)
  ) u_tx_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (tx_load),
    .src_en  (src_en),
    .period  (period),
    .tick    (tx_tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_phase_q <= 2'h0;
    end else if (tx_load) begin
      tx_phase_q <= 2'h0;
    end else if (tx_tick) begin
      tx_phase_q <= tx_phase_q + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= ubp_pkg::TX_IDLE;
      tx_shift_q <= 9'h000;
      tx_count_q <= 4'h0;
    end else if (tx_load) begin
      tx_state_q <= ubp_pkg::TX_START;
      tx_shift_q <= {ctrl_q[ubp_pkg::BIT_TB8], wbyte};
      tx_count_q <= 4'h0;
    end else if (tx_bit_end) begin
      case (tx_state_q)
        ubp_pkg::TX_START: tx_state_q <= ubp_pkg::TX_DATA;
        ubp_pkg::TX_DATA: begin
          tx_shift_q <= {1'b0, tx_shift_q[8:1]};
          tx_count_q <= tx_count_q + 4'h1;
          if (tx_count_q == frame_bits - 4'h1) begin
            tx_state_q <= ubp_pkg::TX_STOP;
          end
        end
        ubp_pkg::TX_STOP:  tx_state_q <= ubp_pkg::TX_IDLE;
        default:           tx_state_q <= ubp_pkg::TX_IDLE;
      endcase
    end
  end

  // done at start of stop bit
  assign tx_done_set = tx_bit_end & (tx_state_q == ubp_pkg::TX_DATA) &
                       (tx_count_q == frame_bits - 4'h1);

  // low start, data, high stop, idle high
  logic serial_tx_line;
  always_comb begin
    case (tx_state_q)
      ubp_pkg::TX_START: serial_tx_line = 1'b0;
      ubp_pkg::TX_DATA:  serial_tx_line = tx_shift_q[0];
      default:           serial_tx_line = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  ubp_pkg::ubp_rx_state_e rx_state_q;
  logic [8:0]             rx_shift_q;
  logic [3:0]             rx_count_q;
  logic [1:0]             rx_phase_q;
  logic [7:0]             rx_buf_q;
  logic                   rx_b8_q;
  logic                   rx_prev_q;
  logic                   rx_tick;
  logic                   rx_start;
  logic                   rx_mid;
  logic                   rx_done_set;

  assign rx_start = rx_enable & (rx_state_q == ubp_pkg::RX_IDLE) & rx_prev_q & ~rx_pin_i;
  assign rx_mid   = rx_tick & (rx_phase_q == 2'(ubp_pkg::MID_PHASE));

  ubp_baud_gen #(
    .W(ubp_pkg::PERIOD_W)
  ) u_rx_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (rx_start),
    .src_en  (src_en),
    .period  (period),
    .tick    (rx_tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_q  <= 1'b1;
      rx_phase_q <= 2'h0;
    end else begin
      rx_prev_q <= rx_pin_i;
      if (rx_start) begin
        rx_phase_q <= 2'h0;
      end else if (rx_tick) begin
        rx_phase_q <= rx_phase_q + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= ubp_pkg::RX_IDLE;
      rx_shift_q <= 9'h000;
      rx_count_q <= 4'h0;
    end else if (!rx_enable) begin
      rx_state_q <= ubp_pkg::RX_IDLE;
    end else if (rx_start) begin
      rx_state_q <= ubp_pkg::RX_START;
      rx_count_q <= 4'h0;
    end else if (rx_mid) begin
      case (rx_state_q)
        ubp_pkg::RX_START: rx_state_q <= rx_pin_i ? ubp_pkg::RX_IDLE : ubp_pkg::RX_DATA;
        ubp_pkg::RX_DATA: begin
          rx_shift_q <= frame_bits[0] ? {rx_pin_i, rx_shift_q[8:1]}
                                      : {1'b0, rx_pin_i, rx_shift_q[7:1]};
          rx_count_q <= rx_count_q + 4'h1;
          if (rx_count_q == frame_bits - 4'h1) begin
            rx_state_q <= ubp_pkg::RX_STOP;
          end
        end
        ubp_pkg::RX_STOP:  rx_state_q <= ubp_pkg::RX_IDLE;
        default:           rx_state_q <= ubp_pkg::RX_IDLE;
      endcase
    end
  end

  // done at middle of stop bit
  assign rx_done_set = rx_enable & rx_mid & (rx_state_q == ubp_pkg::RX_STOP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_q <= ubp_pkg::RST_BYTE;
      rx_b8_q  <= 1'b0;
    end else if (rx_done_set) begin
      rx_buf_q <= rx_shift_q[7:0];
      rx_b8_q  <= rx_shift_q[8];
    end
  end

  // ----------------------------------------------------------------
  // event flags and interrupt
  // ----------------------------------------------------------------
  logic [1:0] flags_q;
  logic [1:0] flags_clr;
  logic [1:0] flags_set;

  assign flags_set = {tx_done_set, rx_done_set};
  assign flags_clr = (wr & (idx == ubp_pkg::IDX_STATUS)) ? wbyte[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 2'h0;
    end else begin
      // cleared only by software write of one; set wins
      flags_q <= (flags_q & ~flags_clr) | flags_set;
    end
  end

  assign irq = irq_en_q[ubp_pkg::BIT_GLOBAL_IE] & irq_en_q[ubp_pkg::BIT_SERIAL_IE] &
               (|(flags_q & mask_q));

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  logic tx_level;

  // line can only pull the latch level low
  assign tx_level  = port0_latch_q[ubp_pkg::BIT_TX_PIN] & serial_tx_line;
  assign tx_pin.o  = tx_level;
  assign tx_pin.oe = direction_q[ubp_pkg::BIT_TX_PIN] &
                     (~open_drain_q[ubp_pkg::BIT_TX_OD] | ~tx_level);
  assign rx_pin.o  = port0_latch_q[ubp_pkg::BIT_RX_PIN];
  assign rx_pin.oe = direction_q[ubp_pkg::BIT_RX_PIN] &
                     (~open_drain_q[ubp_pkg::BIT_RX_OD] | ~port0_latch_q[ubp_pkg::BIT_RX_PIN]);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] rbyte;

  always_comb begin
    rbyte = 8'h00;
    case (idx)
      ubp_pkg::IDX_PORT0: begin
        rbyte = port0_latch_q;
        rbyte[ubp_pkg::BIT_RX_PIN] = rx_pin_i;
        rbyte[ubp_pkg::BIT_TX_PIN] = tx_pin_i;
      end
      ubp_pkg::IDX_POWER:      rbyte = power_q;
      ubp_pkg::IDX_CTRL:       rbyte = {ctrl_q[7:3], rx_b8_q, flags_q};
      ubp_pkg::IDX_DATA:       rbyte = rx_buf_q;
      ubp_pkg::IDX_IRQ_EN:     rbyte = irq_en_q;
      ubp_pkg::IDX_RELOAD_LO:  rbyte = reload_lo_q;
      ubp_pkg::IDX_RELOAD_HI:  rbyte = {6'h00, reload_hi_q};
      ubp_pkg::IDX_CTRL2:      rbyte = {baud_src_q, 7'h00};
      ubp_pkg::IDX_OPEN_DRAIN: rbyte = open_drain_q;
      ubp_pkg::IDX_DIRECTION:  rbyte = direction_q;
      ubp_pkg::IDX_STATUS:     rbyte = {6'h00, flags_q};
      ubp_pkg::IDX_MASK:       rbyte = {6'h00, mask_q};
      default:                 rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= {24'h000000, rbyte};
    end
  end

endmodule

// [tb/ubp_sp_sva.sv]
// concurrent checks on the serial port block ports
// assumes it is bound onto ubp_serial_port
`timescale 1ns/1ps
module ubp_sp_sva (
  input wire logic                       pclk,     // clock
  input wire logic                       presetn,  // reset, low
  input wire logic                       psel,     // select
  input wire logic                       penable,  // enable
  input wire logic                       pwrite,   // direction
  input wire logic [ubp_pkg::ADDR_W-1:0] paddr,    // byte address
  input wire logic [31:0]                pwdata,   // write data
  input wire logic [31:0]                prdata,   // read data
  input wire logic                       rx_pin_i, // rx level
  input wire ubp_pkg::ubp_pin_s          tx_pin,   // tx drive
  input wire logic                       irq       // interrupt
);
  logic [7:0] p0_q, pw_q, ctl_q, ie_q, od_q;
  logic [9:0] idx;
  logic       wr, rd, wd;
  assign idx = paddr[11:2];
  assign wr  = psel && penable && pwrite;
  assign rd  = psel && penable && !pwrite;
  assign wd  = wr && idx == ubp_pkg::IDX_DATA && p0_q[5];
  // ------------------------------------------
  // shadow of written registers
  // ------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {p0_q, pw_q, ctl_q, ie_q, od_q} <= 40'h0;
    end else if (wr) begin
      if (idx == ubp_pkg::IDX_PORT0) p0_q <= pwdata[7:0];
      if (idx == ubp_pkg::IDX_POWER) pw_q <= pwdata[7:0];
      if (idx == ubp_pkg::IDX_CTRL) ctl_q <= pwdata[7:0];
      if (idx == ubp_pkg::IDX_IRQ_EN) ie_q <= pwdata[7:0];
      if (idx == ubp_pkg::IDX_OPEN_DRAIN) od_q <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_irq_needs_enables:
    assert property (irq |-> ie_q[7] && ie_q[4]) else $error("irq without enables");
  a_od_tx_low:
    assert property (tx_pin.oe && od_q[3] |-> !tx_pin.o) else $error("open-drain tx drove high");
  a_tx_latch_low:
    assert property (!p0_q[5] |-> !tx_pin.o) else $error("tx high with latch low");
  a_start_bit_low:
    assert property (wd |=> !tx_pin.o) else $error("no start bit");
  a_reload_hi_zero:
    assert property (rd && idx == ubp_pkg::IDX_RELOAD_HI |-> prdata[7:2] == 6'h00) else $error("reload high bits");
  a_rx_level_read:
    assert property (rd && idx == ubp_pkg::IDX_PORT0 && $stable(rx_pin_i) |-> prdata[6] == rx_pin_i)
      else $error("rx level read");
  a_mode2_slow_bit:
    assert property (wd && ctl_q[7:6] == 2'h2 && !pw_q[7] |-> ##64 !tx_pin.o ##1 tx_pin.o == $past(pwdata[0], 65))
      else $error("mode 2 slow bit time");
  a_mode2_fast_bit:
    assert property (wd && ctl_q[7:6] == 2'h2 && pw_q[7] |-> ##32 !tx_pin.o ##1 tx_pin.o == $past(pwdata[0], 33))
      else $error("mode 2 fast bit time");
  a_mode0_fixed_bit:
    assert property (wd && ctl_q[7:6] == 2'h0 |-> ##12 !tx_pin.o ##1 tx_pin.o == $past(pwdata[0], 13))
      else $error("mode 0 bit time");
endmodule
bind ubp_serial_port ubp_sp_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .rx_pin_i(rx_pin_i), .tx_pin(tx_pin), .irq(irq)
);

// [tb/ubp_uart_remote.sv]
// remote serial transceiver on the tx and rx lines
// assumes 8 data bits at a fixed bit time in clocks
`timescale 1ns/1ps
module ubp_uart_remote (
  input  wire logic        clk,      // bench clock
  input  wire logic        line_in,  // line from block
  output logic             line_out, // line to block
  input  wire logic [15:0] bit_cyc   // clocks per bit
);
  logic [7:0] got;
  logic [7:0] sh;
  int         n_got = 0;
  initial line_out = 1'b1;
  always begin
    @(negedge line_in);
    repeat (bit_cyc / 2) @(posedge clk);
    if (line_in == 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge clk);
        sh[i] = line_in;
      end
      repeat (bit_cyc) @(posedge clk);
      got = sh;
      n_got++;
    end
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (bit_cyc - 16'h1) @(posedge clk);
    end
  endtask
  task automatic set_line(input logic v);
    @(posedge clk);
    line_out <= v;
  endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the serial port block
// assumes the remote model on the serial lines
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic pready, pslverr, irq, tx_w, rx_w, rem_line, err_q;
  logic t1_ov = 1'b0;
  logic [15:0] bit_cyc = 16'h0020;
  ubp_pkg::ubp_pin_s tx_pin, rx_pin;
  int failures = 0, n_checks = 0;
  logic [9:0] rz [7] = '{ubp_pkg::IDX_RELOAD_LO, ubp_pkg::IDX_RELOAD_HI, ubp_pkg::IDX_IRQ_EN,
    ubp_pkg::IDX_OPEN_DRAIN, ubp_pkg::IDX_DIRECTION, ubp_pkg::IDX_POWER, ubp_pkg::IDX_DATA};
  logic [7:0] pwv [3] = '{8'h00, 8'h80, 8'h80};
  logic [7:0] mdv [3] = '{8'h80, 8'h80, 8'h00};
  assign tx_w = tx_pin.oe ? tx_pin.o : 1'b1;
  assign rx_w = rx_pin.oe ? (rx_pin.o & rem_line) : rem_line;
  always #5 pclk = ~pclk;
  always @(posedge pclk) t1_ov <= ~t1_ov;
  ubp_serial_port uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .t1_overflow(t1_ov),
    .tx_pin_i(tx_w), .tx_pin(tx_pin), .rx_pin_i(rx_w), .rx_pin(rx_pin), .irq(irq)
  );
  ubp_uart_remote u_rem (.clk(pclk), .line_in(tx_w), .line_out(rem_line), .bit_cyc(bit_cyc));
  task automatic finish_test();
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin failures++; finish_test(); end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd_q, exp);
  endtask
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    do begin apb(1'b0, ubp_pkg::IDX_STATUS, 8'h00); n++; end while (rd_q[b] !== 1'b1 && n < 400);
    if (n >= 400) begin failures++; finish_test(); end
  endtask
  task automatic wait_rem(input int k);
    int n;
    n = 0;
    while (u_rem.n_got < k && n < 1000) begin @(posedge pclk); n++; end
    if (n >= 1000) begin failures++; finish_test(); end
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(ubp_pkg::IDX_PORT0, 32'h60);
    chk({tx_pin, rx_pin}, 32'h0);
    foreach (rz[i]) rdchk(rz[i], 32'h0);
    apb(1'b1, ubp_pkg::IDX_RELOAD_HI, 8'hFF);
    rdchk(ubp_pkg::IDX_RELOAD_HI, 32'h03);
    apb(1'b1, ubp_pkg::IDX_RELOAD_LO, 8'hFF);
    rdchk(ubp_pkg::IDX_RELOAD_LO, 32'hFF);
    apb(1'b0, 10'h3FF, 8'h00);
    chk({rd_q[31:1], err_q}, 32'h1);
    apb(1'b1, ubp_pkg::IDX_PORT0, 8'h20);
    apb(1'b1, ubp_pkg::IDX_DIRECTION, 8'h20);
    chk({tx_pin, rx_pin}, 32'hC);
    apb(1'b1, ubp_pkg::IDX_CTRL, 8'h50);
    apb(1'b1, ubp_pkg::IDX_CTRL2, 8'h80);
    apb(1'b1, ubp_pkg::IDX_POWER, 8'h80);
    apb(1'b1, ubp_pkg::IDX_DATA, 8'hA5);
    wait_flag(1);
    wait_rem(1);
    chk(u_rem.got, 32'hA5);
    chk(irq, 32'h0);
    apb(1'b1, ubp_pkg::IDX_IRQ_EN, 8'h10);
    chk(irq, 32'h0);
    apb(1'b1, ubp_pkg::IDX_IRQ_EN, 8'h90);
    chk(irq, 32'h1);
    apb(1'b1, ubp_pkg::IDX_MASK, 8'h01);
    chk(irq, 32'h0);
    apb(1'b1, ubp_pkg::IDX_MASK, 8'h03);
    apb(1'b1, ubp_pkg::IDX_STATUS, 8'h02);
    chk(irq, 32'h0);
    u_rem.send(8'h3C);
    wait_flag(0);
    rdchk(ubp_pkg::IDX_DATA, 32'h3C);
    chk(irq, 32'h1);
    apb(1'b1, ubp_pkg::IDX_STATUS, 8'h01);
    apb(1'b1, ubp_pkg::IDX_OPEN_DRAIN, 8'h10);
    u_rem.send(8'h55);
    repeat (40) @(posedge pclk);
    rdchk(ubp_pkg::IDX_STATUS, 32'h0);
    rdchk(ubp_pkg::IDX_DATA, 32'h3C);
    apb(1'b1, ubp_pkg::IDX_OPEN_DRAIN, 8'h08);
    apb(1'b1, ubp_pkg::IDX_DATA, 8'h5A);
    wait_rem(2);
    chk(u_rem.got, 32'h5A);
    apb(1'b1, ubp_pkg::IDX_CTRL2, 8'h00);
    apb(1'b1, ubp_pkg::IDX_DATA, 8'hC3);
    wait_rem(3);
    chk(u_rem.got, 32'hC3);
    u_rem.set_line(1'b0);
    rdchk(ubp_pkg::IDX_PORT0, 32'h20);
    u_rem.set_line(1'b1);
    apb(1'b1, ubp_pkg::IDX_OPEN_DRAIN, 8'h00);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ubp_pkg::IDX_STATUS, 8'h03);
      apb(1'b1, ubp_pkg::IDX_POWER, pwv[i]);
      apb(1'b1, ubp_pkg::IDX_CTRL, mdv[i]);
      apb(1'b1, ubp_pkg::IDX_DATA, 8'h01);
      wait_flag(1);
    end
    finish_test();
  end
endmodule
